// *** core/tlvic_consts.svh ***
`ifndef TLVIC_CONSTS_SVH
`define TLVIC_CONSTS_SVH

// ==========================================================================
// Register addresses
`define TLVIC_ADDR_ENABLE   8'ha8
`define TLVIC_ADDR_PRIORITY 8'hb8
`define TLVIC_ADDR_TCTRL    8'h88
`define TLVIC_ADDR_SCTRL    8'h98
`define TLVIC_ADDR_T2CTRL   8'hc8

// ==========================================================================
// Enable / priority bit positions
`define TLVIC_BIT_EX0       0
`define TLVIC_BIT_ET0       1
`define TLVIC_BIT_EX1       2
`define TLVIC_BIT_ET1       3
`define TLVIC_BIT_ES        4
`define TLVIC_BIT_ET2       5
`define TLVIC_BIT_GLOBAL    7

// ==========================================================================
// Flag bit positions
`define TLVIC_BIT_IT0       0
`define TLVIC_BIT_IE0F      1
`define TLVIC_BIT_IT1       2
`define TLVIC_BIT_IE1F      3
`define TLVIC_BIT_TF0       5
`define TLVIC_BIT_TF1       7
`define TLVIC_BIT_RX        0
`define TLVIC_BIT_TX        1
`define TLVIC_BIT_TIMER2_EXTERNAL_FLAG      6
`define TLVIC_BIT_TF2       7

// ==========================================================================
// Reset values and vectors
`define TLVIC_RST_BYTE      8'h00
`define TLVIC_VEC_EXT0      16'h0003
`define TLVIC_VEC_TMR0      16'h000b
`define TLVIC_VEC_EXT1      16'h0013
`define TLVIC_VEC_TMR1      16'h001b
`define TLVIC_VEC_SER       16'h0023
`define TLVIC_VEC_TMR2      16'h002b
`define TLVIC_VEC_RESET     16'h0000

`endif

// *** core/tlvic_pkg.sv ***
package tlvic_pkg;

  typedef enum logic [2:0] {
    SRC_EXT0,
    SRC_TMR0,
    SRC_EXT1,
    SRC_TMR1,
    SRC_SER,
    SRC_TMR2,
    SRC_NONE
  } tlvic_src_type;

  typedef struct packed {
    logic          valid;
    logic          high;
    tlvic_src_type src;
  } tlvic_pick_type;

endpackage : tlvic_pkg

// *** core/tlvic_arb_if.sv ***
// ==========================================================================
// Arbiter connection
interface tlvic_arb_if;
  import tlvic_pkg::*;
  logic [5:0]     req;
  logic [5:0]     prio;
  tlvic_pick_type pick;
  modport ctrl (output req, output prio, input pick);
  modport arb  (input req, input prio, output pick);
endinterface : tlvic_arb_if

// *** core/tlvic_arb.sv ***
`include "tlvic_consts.svh"

// ==========================================================================
// Two-level fixed-order arbiter
module tlvic_arb
  import tlvic_pkg::*;
(
  tlvic_arb_if.arb a  // Requests in, winner out
);

  function automatic tlvic_pick_type pick_level(input logic [5:0] r);
    tlvic_pick_type p;
    p = '{valid: 1'b1, high: 1'b0, src: SRC_NONE};
    if (r[SRC_EXT0]) begin
      p.src = SRC_EXT0;
    end else if (r[SRC_TMR0]) begin
      p.src = SRC_TMR0;
    end else if (r[SRC_EXT1]) begin
      p.src = SRC_EXT1;
    end else if (r[SRC_TMR1]) begin
      p.src = SRC_TMR1;
    end else if (r[SRC_SER]) begin
      p.src = SRC_SER;
    end else if (r[SRC_TMR2]) begin
      p.src = SRC_TMR2;
    end else begin
      p.valid = 1'b0;
    end
    return p;
  endfunction : pick_level

  tlvic_pick_type hi;
  tlvic_pick_type lo;

  always_comb begin
    hi      = pick_level(a.req & a.prio);
    lo      = pick_level(a.req & ~a.prio);
    hi.high = 1'b1;
    a.pick  = hi.valid ? hi : lo;
  end

endmodule : tlvic_arb

// *** core/tlvic_ctrl.sv ***
`include "tlvic_consts.svh"

module tlvic_ctrl
  import tlvic_pkg::*;
(
  input  wire logic        i_clk,              // 20 MHz clock
  input  wire logic        i_reset_n,          // Async reset, active low
  input  wire logic        i_ext_req0_pin_n,   // External request 0 pin
  input  wire logic        i_ext_req1_pin_n,   // External request 1 pin
  input  wire logic        i_state5_phase2_sample, // Sample strobe, once a cycle
  input  wire logic        i_state2_phase2_point,  // Timer 2 overflow point
  input  wire logic        i_last_cycle,       // Final cycle of instruction
  input  wire logic        i_instr_return_from_isr,       // Instruction is return_from_isr
  input  wire logic        i_instr_ret,        // Instruction is plain return
  input  wire logic        i_timer0_mode3,     // Timer 0 in mode 3
  input  wire logic        i_timer0_rollover,  // Timer 0 rollover pulse
  input  wire logic        i_timer1_rollover,  // Timer 1 rollover pulse
  input  wire logic        i_timer2_rollover,  // Timer 2 overflow pulse
  input  wire logic        i_timer2_ext_event, // Timer 2 external event pulse
  input  wire logic        i_rx_done,          // Receive done pulse
  input  wire logic        i_tx_done,          // Transmit done pulse
  input  wire logic        i_wr_en,            // Register write strobe
  input  wire logic [7:0]  i_wr_addr,          // Register write address
  input  wire logic [7:0]  i_wr_data,          // Register write data
  input  wire logic [7:0]  i_rd_addr,          // Register read address
  output logic [7:0]       o_rd_data,          // Registered read data
  output logic             o_hw_vector_call,   // Vector call pulse
  output logic [15:0]      o_vector_addr,      // Vector address
  output logic [1:0]       o_in_progress       // Busy levels: 1 high, 0 low
);

  typedef struct packed {
    logic [1:0]  pin0_sync;
    logic [1:0]  pin1_sync;
    logic        pin0_prev;
    logic        pin1_prev;
    logic [7:0]  tctrl;
    logic [7:0]  sctrl;
    logic [7:0]  t2ctrl;
    logic [7:0]  enable;
    logic [7:0]  prio;
    logic [5:0]  sampled;
    logic [5:0]  sampled_prio;
    logic        t2_ovf_now;
    logic        blocked_write;
    logic [1:0]  busy;
    logic [1:0]  busy_stack;
    logic        call;
    logic [15:0] vec;
    logic [7:0]  rd_data;
  } tlvic_state_type;

  tlvic_state_type state_r;
  tlvic_state_type state_nxt;

  tlvic_arb_if arb_bus ();

  tlvic_arb u_arb (
    .a (arb_bus.arb)
  );

  // ========================================================================
  // Helpers
  function automatic logic [15:0] vec_of(input tlvic_src_type s);
    unique case (s)
      SRC_EXT0: vec_of = `TLVIC_VEC_EXT0;
      SRC_TMR0: vec_of = `TLVIC_VEC_TMR0;
      SRC_EXT1: vec_of = `TLVIC_VEC_EXT1;
      SRC_TMR1: vec_of = `TLVIC_VEC_TMR1;
      SRC_SER:  vec_of = `TLVIC_VEC_SER;
      SRC_TMR2: vec_of = `TLVIC_VEC_TMR2;
      default:  vec_of = `TLVIC_VEC_RESET;
    endcase
  endfunction : vec_of

  function automatic logic [5:0] src_bits(input logic [7:0] r);
    src_bits = {r[`TLVIC_BIT_ET2], r[`TLVIC_BIT_ES], r[`TLVIC_BIT_ET1],
                r[`TLVIC_BIT_EX1], r[`TLVIC_BIT_ET0], r[`TLVIC_BIT_EX0]};
  endfunction : src_bits

  function automatic logic wr_hit(input logic en, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = en && (a == target);
  endfunction : wr_hit

  // ========================================================================
  // Next state
  logic        fall0;
  logic        fall1;
  logic        t2_req;
  logic [5:0]  req_now;
  logic [5:0]  eff_req;
  logic        can_call;
  logic        ext0_edge;
  logic        ext1_edge;
  logic        wr_ie_ip;

  always_comb begin
    state_nxt = state_r;
    ext0_edge = state_r.tctrl[`TLVIC_BIT_IT0];
    ext1_edge = state_r.tctrl[`TLVIC_BIT_IT1];
    fall0     = 1'b0;
    fall1     = 1'b0;
    t2_req    = 1'b0;
    req_now   = 6'h00;
    eff_req   = 6'h00;
    can_call  = 1'b0;
    wr_ie_ip  = wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_ENABLE) ||
                wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_PRIORITY);

    // Pin synchronisers
    state_nxt.pin0_sync = {state_r.pin0_sync[0], i_ext_req0_pin_n};
    state_nxt.pin1_sync = {state_r.pin1_sync[0], i_ext_req1_pin_n};
    state_nxt.call      = 1'b0;

    // Software register writes act like hardware set/clear
    if (wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_TCTRL)) begin
      state_nxt.tctrl = i_wr_data;
    end
    if (wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_SCTRL)) begin
      state_nxt.sctrl = i_wr_data;
    end
    if (wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_T2CTRL)) begin
      state_nxt.t2ctrl = i_wr_data;
    end
    if (wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_ENABLE)) begin
      state_nxt.enable = i_wr_data;
    end
    if (wr_hit(i_wr_en, i_wr_addr, `TLVIC_ADDR_PRIORITY)) begin
      state_nxt.prio = i_wr_data;
    end

    // Hardware flag sets, at the sampling point or on a pulse, win over writes
    if (i_state5_phase2_sample) begin
      state_nxt.pin0_prev = state_r.pin0_sync[1];
      state_nxt.pin1_prev = state_r.pin1_sync[1];
      fall0 = state_r.pin0_prev && !state_r.pin0_sync[1];
      fall1 = state_r.pin1_prev && !state_r.pin1_sync[1];
      if (ext0_edge) begin
        if (fall0) state_nxt.tctrl[`TLVIC_BIT_IE0F] = 1'b1;
      end else begin
        state_nxt.tctrl[`TLVIC_BIT_IE0F] = !state_r.pin0_sync[1];
      end
      if (ext1_edge) begin
        if (fall1) state_nxt.tctrl[`TLVIC_BIT_IE1F] = 1'b1;
      end else begin
        state_nxt.tctrl[`TLVIC_BIT_IE1F] = !state_r.pin1_sync[1];
      end
    end
    if (i_timer0_rollover && !i_timer0_mode3) begin
      state_nxt.tctrl[`TLVIC_BIT_TF0] = 1'b1;
    end
    if (i_timer1_rollover) begin
      state_nxt.tctrl[`TLVIC_BIT_TF1] = 1'b1;
    end
    if (i_rx_done) state_nxt.sctrl[`TLVIC_BIT_RX] = 1'b1;
    if (i_tx_done) state_nxt.sctrl[`TLVIC_BIT_TX] = 1'b1;
    if (i_timer2_rollover) state_nxt.t2ctrl[`TLVIC_BIT_TF2] = 1'b1;
    if (i_timer2_ext_event) state_nxt.t2ctrl[`TLVIC_BIT_TIMER2_EXTERNAL_FLAG] = 1'b1;

    // Timer 2 overflow seen at state 2 is registered and polled in the next cycle
    if (i_state2_phase2_point && i_timer2_rollover) begin
      state_nxt.t2_ovf_now = 1'b1;
    end

    // Current request levels
    t2_req = state_r.t2ctrl[`TLVIC_BIT_TF2] | state_r.t2ctrl[`TLVIC_BIT_TIMER2_EXTERNAL_FLAG];
    req_now[SRC_EXT0] = state_r.tctrl[`TLVIC_BIT_IE0F];
    req_now[SRC_TMR0] = state_r.tctrl[`TLVIC_BIT_TF0];
    req_now[SRC_EXT1] = state_r.tctrl[`TLVIC_BIT_IE1F];
    req_now[SRC_TMR1] = state_r.tctrl[`TLVIC_BIT_TF1];
    req_now[SRC_SER]  = state_r.sctrl[`TLVIC_BIT_RX] | state_r.sctrl[`TLVIC_BIT_TX];
    req_now[SRC_TMR2] = t2_req;

    // Sample once per machine cycle; no memory of older samples
    if (i_state5_phase2_sample) begin
      state_nxt.sampled      = req_now & src_bits(state_r.enable) &
                               {6{state_r.enable[`TLVIC_BIT_GLOBAL]}};
      state_nxt.sampled_prio = src_bits(state_r.prio);
      state_nxt.t2_ovf_now   = 1'b0;
      state_nxt.blocked_write = 1'b0;
    end
    if (wr_ie_ip || i_instr_return_from_isr) begin
      state_nxt.blocked_write = 1'b1;
    end

    eff_req = state_r.sampled;
    eff_req[SRC_TMR2] = state_r.sampled[SRC_TMR2] |
                        (state_r.t2_ovf_now && state_r.enable[`TLVIC_BIT_ET2] &&
                         state_r.enable[`TLVIC_BIT_GLOBAL]);
    arb_bus.req  = eff_req;
    arb_bus.prio = state_r.sampled_prio;

    // Blocking conditions
    can_call = arb_bus.pick.valid && i_last_cycle && !i_instr_return_from_isr && !wr_ie_ip &&
               !state_r.blocked_write && !state_r.busy[1] &&
               (arb_bus.pick.high || !state_r.busy[0]);

    if (can_call) begin
      state_nxt.call = 1'b1;
      state_nxt.vec  = vec_of(arb_bus.pick.src);
      state_nxt.busy_stack = state_r.busy;
      if (arb_bus.pick.high) state_nxt.busy[1] = 1'b1;
      else state_nxt.busy[0] = 1'b1;
      state_nxt.sampled = 6'h00;
      unique case (arb_bus.pick.src)
        SRC_EXT0: if (ext0_edge) state_nxt.tctrl[`TLVIC_BIT_IE0F] = 1'b0;
        SRC_EXT1: if (ext1_edge) state_nxt.tctrl[`TLVIC_BIT_IE1F] = 1'b0;
        SRC_TMR0: state_nxt.tctrl[`TLVIC_BIT_TF0] = 1'b0;
        SRC_TMR1: state_nxt.tctrl[`TLVIC_BIT_TF1] = 1'b0;
        default: ;
      endcase
      if (arb_bus.pick.src == SRC_TMR2) state_nxt.t2_ovf_now = 1'b0;
    end else if (i_instr_return_from_isr && i_last_cycle) begin
      // Clear highest busy level, restoring the lower one
      if (state_r.busy[1]) state_nxt.busy[1] = 1'b0;
      else state_nxt.busy[0] = 1'b0;
    end
    // A plain return leaves the busy levels untouched
    if (i_instr_ret) state_nxt.busy = state_nxt.busy;

    // Read port
    unique case (i_rd_addr)
      `TLVIC_ADDR_ENABLE:   state_nxt.rd_data = state_r.enable;
      `TLVIC_ADDR_PRIORITY: state_nxt.rd_data = state_r.prio;
      `TLVIC_ADDR_TCTRL:    state_nxt.rd_data = state_r.tctrl;
      `TLVIC_ADDR_SCTRL:    state_nxt.rd_data = state_r.sctrl;
      `TLVIC_ADDR_T2CTRL:   state_nxt.rd_data = state_r.t2ctrl;
      default:              state_nxt.rd_data = `TLVIC_RST_BYTE;
    endcase
  end

  // ========================================================================
  // State register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r           <= '0;
      state_r.pin0_sync <= 2'h3;
      state_r.pin1_sync <= 2'h3;
      state_r.pin0_prev <= 1'b1;
      state_r.pin1_prev <= 1'b1;
      state_r.prio      <= `TLVIC_RST_BYTE;
      state_r.enable    <= `TLVIC_RST_BYTE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_rd_data        = state_r.rd_data;
  assign o_hw_vector_call = state_r.call;
  assign o_vector_addr    = state_r.vec;
  assign o_in_progress    = state_r.busy;

endmodule : tlvic_ctrl

// *** testbench/tlvic_ctrl_monitor.sv ***
`include "tlvic_consts.svh"

// ==========================================
// Port checks of the controller
module tlvic_monitor (
  input wire logic        i_clk,            // Clock
  input wire logic        i_reset_n,        // Reset, active low
  input wire logic        i_last_cycle,     // Last cycle
  input wire logic        i_instr_return_from_isr,     // Return from isr
  input wire logic        o_hw_vector_call, // Vector call
  input wire logic [15:0] o_vector_addr,    // Vector address
  input wire logic [1:0]  o_in_progress     // Busy levels
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  call_sets_busy_a: assert property (o_hw_vector_call |-> o_in_progress != 2'h0)
    else $error("Call without busy");
  vector_legal_a: assert property (o_hw_vector_call |-> o_vector_addr[15:6] == 10'h0 &&
    o_vector_addr[2:0] == 3'h3 && o_vector_addr[5:3] < 3'h6) else $error("Bad vector");
  busy_needs_call_a: assert property (
    (o_in_progress & ~$past(o_in_progress)) != 2'h0 |-> o_hw_vector_call)
    else $error("Busy without call");
  busy_drop_return_from_isr_a: assert property (
    (~o_in_progress & $past(o_in_progress)) != 2'h0 |-> $past(i_instr_return_from_isr) &&
    $past(i_last_cycle)) else $error("Busy dropped without return");
  return_from_isr_pops_level_a: assert property (i_instr_return_from_isr && i_last_cycle |=>
    o_in_progress == {1'b0, $past(o_in_progress) == 2'h3}) else $error("Wrong level freed");
  high_no_preempt_a: assert property (
    o_in_progress[1] && $past(o_in_progress[1]) |-> !o_hw_vector_call)
    else $error("High preempted");
  low_only_high_a: assert property (
    o_hw_vector_call && $past(o_in_progress[0]) |-> o_in_progress == 2'h3)
    else $error("Low preempted by low");
  call_blocked_a: assert property (o_hw_vector_call |->
    $past(i_last_cycle) && !$past(i_instr_return_from_isr)) else $error("Call in blocked cycle");
endmodule : tlvic_monitor

bind tlvic_ctrl tlvic_monitor u_mon (.i_clk(i_clk), .i_reset_n(i_reset_n),
  .i_last_cycle(i_last_cycle), .i_instr_return_from_isr(i_instr_return_from_isr), .o_hw_vector_call(o_hw_vector_call),
  .o_vector_addr(o_vector_addr), .o_in_progress(o_in_progress));

// *** testbench/tlvic_seq_model.sv ***
// ==========================================
// Instruction sequencer model
module tlvic_seq_model (
  input  wire logic i_clk,      // Clock
  input  wire logic i_reset_n,  // Reset, active low
  input  wire logic i_hold,     // Stretch instruction
  input  wire logic i_return_from_isr_req, // Run return from isr
  input  wire logic i_ret_req,  // Run plain return
  output logic      o_sample,   // State 5 strobe
  output logic      o_point,    // State 2 strobe
  output logic      o_last,     // Last cycle
  output logic      o_return_from_isr,     // Return from isr
  output logic      o_ret       // Plain return
);
  timeunit 1ns;
  timeprecision 1ns;
  logic phase_r;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end
  assign o_sample = i_reset_n & phase_r;
  assign o_point  = i_reset_n & ~phase_r;
  assign o_last   = ~i_hold | i_return_from_isr_req | i_ret_req;
  assign o_return_from_isr   = i_return_from_isr_req;
  assign o_ret    = i_ret_req;
endmodule : tlvic_seq_model

// *** testbench/tlvic_ctrl_tb.sv ***
// ==========================================
// Bench
module tlvic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        pin0 = 1'b1;
  logic        pin1 = 1'b1;
  logic        hold = 1'b0;
  logic        return_from_isr_q = 1'b0;
  logic        ret_q = 1'b0;
  logic        mode3 = 1'b0;
  logic        wr_en = 1'b0;
  logic [5:0]  pls = 6'h0;
  logic [7:0]  wr_addr = 8'h0;
  logic [7:0]  wr_data = 8'h0;
  logic [7:0]  rd_addr = 8'h0;
  logic [7:0]  rd_data;
  logic [15:0] vec;
  logic [1:0]  busy;
  logic        call, smp, pnt, last, return_from_isr, ret;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  tlvic_seq_model seq (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hold(hold), .i_return_from_isr_req(return_from_isr_q),
    .i_ret_req(ret_q), .o_sample(smp), .o_point(pnt), .o_last(last), .o_return_from_isr(return_from_isr), .o_ret(ret));
  tlvic_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ext_req0_pin_n(pin0),
    .i_ext_req1_pin_n(pin1), .i_state5_phase2_sample(smp), .i_state2_phase2_point(pnt),
    .i_last_cycle(last), .i_instr_return_from_isr(return_from_isr), .i_instr_ret(ret), .i_timer0_mode3(mode3),
    .i_timer0_rollover(pls[0]), .i_timer1_rollover(pls[1]), .i_timer2_rollover(pls[2]),
    .i_rx_done(pls[3]), .i_tx_done(pls[4]), .i_timer2_ext_event(pls[5]), .i_wr_en(wr_en),
    .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .o_hw_vector_call(call), .o_vector_addr(vec), .o_in_progress(busy));

  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge i_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge i_clk);
    rd_addr <= a;
    repeat (2) @(posedge i_clk);
    #1 check({8'h0, rd_data & m}, {8'h0, e});
  endtask : rd

  task automatic wait_call(input logic [15:0] v, input logic [1:0] b);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1 n++;
    end while (call !== 1'b1 && n < 40);
    check({call, busy, vec[12:0]}, {1'b1, b, v[12:0]});
  endtask : wait_call

  task automatic no_call(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge i_clk);
      #1 seen |= (call !== 1'b0);
    end
    check({15'h0, seen}, 16'h0);
  endtask : no_call

  task automatic ret_op(input logic full, input logic [1:0] b);
    @(posedge i_clk);
    return_from_isr_q <= full;
    ret_q <= ~full;
    @(posedge i_clk);
    return_from_isr_q <= 1'b0;
    ret_q <= 1'b0;
    #1 check({14'h0, busy}, {14'h0, b});
  endtask : ret_op

  task automatic clear_all();
    wr(8'ha8, 8'h3f);
    wr(8'h88, 8'h05);
    wr(8'h98, 8'h00);
    wr(8'hc8, 8'h00);
  endtask : clear_all

  function automatic logic [7:0] fbit(input int s, input int alt);
    case (s)
      0: return 8'h02;
      1: return 8'h20;
      2: return 8'h08;
      4: return alt ? 8'h02 : 8'h01;
      5: return alt ? 8'h40 : 8'h80;
      default: return 8'h80;
    endcase
  endfunction : fbit

  function automatic int winner(input logic [5:0] m, input logic [5:0] p);
    logic [5:0] h;
    h = (m & p) != 6'h0 ? m & p : m;
    for (int i = 0; i < 6; i++) if (h[i]) return i;
    return 0;
  endfunction : winner

  initial begin
    logic [5:0] m;
    logic [5:0] p;
    int alt;
    void'($urandom(98569));
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    rd(8'ha8, 8'hff, 8'h00);
    rd(8'hb8, 8'hff, 8'h00);
    rd(8'h55, 8'hff, 8'h00);
    wr(8'h88, 8'h05);
    wr(8'ha8, 8'hbf);
    for (int s = 0; s < 6; s++) begin
      alt = $urandom_range(0, 1);
      @(posedge i_clk);
      if (s == 0) pin0 <= 1'b0;
      else if (s == 2) pin1 <= 1'b0;
      else pls <= s == 1 ? 6'h01 : s == 3 ? 6'h02 : s == 4 ? (alt ? 6'h10 : 6'h08) :
                 (alt ? 6'h20 : 6'h04);
      @(posedge i_clk);
      pls <= 6'h0;
      wait_call(16'h0003 + 16'(8 * s), 2'h1);
      @(posedge i_clk);
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      rd(s < 4 ? 8'h88 : s == 4 ? 8'h98 : 8'hc8, fbit(s, alt), s > 3 ? fbit(s, alt) : 8'h00);
      clear_all();
      wr(8'ha8, 8'hbf);
      ret_op(1'b1, 2'h0);
    end
    wr(8'h88, 8'h00);
    @(posedge i_clk);
    pin0 <= 1'b0;
    wait_call(16'h0003, 2'h1);
    rd(8'h88, 8'h02, 8'h02);
    @(posedge i_clk);
    pin0 <= 1'b1;
    // Two synchroniser stages plus a sampling point before the flag drops
    repeat (4) @(posedge i_clk);
    rd(8'h88, 8'h02, 8'h00);
    ret_op(1'b1, 2'h0);
    mode3 <= 1'b1;
    @(posedge i_clk);
    pls <= 6'h01;
    @(posedge i_clk);
    pls <= 6'h00;
    mode3 <= 1'b0;
    rd(8'h88, 8'h20, 8'h00);
    clear_all();
    wr(8'hb8, 8'h02);
    wr(8'h88, 8'h07);
    hold <= 1'b1;
    wr(8'ha8, 8'hbf);
    no_call(8);
    hold <= 1'b0;
    wait_call(16'h0003, 2'h1);
    wr(8'h88, 8'h85);
    no_call(8);
    wr(8'h88, 8'ha5);
    wait_call(16'h000b, 2'h3);
    no_call(6);
    ret_op(1'b1, 2'h1);
    ret_op(1'b0, 2'h1);
    no_call(6);
    ret_op(1'b1, 2'h0);
    wait_call(16'h001b, 2'h1);
    for (int k = 0; k < 12; k++) begin
      m = 6'($urandom_range(1, 63));
      p = 6'($urandom);
      clear_all();
      ret_op(1'b1, 2'h0);
      wr(8'h88, {m[3], 1'b0, m[1], 1'b0, m[2], 1'b1, m[0], 1'b1});
      wr(8'h98, {7'h0, m[4]});
      wr(8'hc8, {m[5], 7'h0});
      wr(8'hb8, {2'h0, p});
      rd(8'hb8, 8'hff, {2'h0, p});
      no_call(4);
      wr(8'ha8, 8'hbf);
      wait_call(16'h0003 + 16'(8 * winner(m, p)), p[winner(m, p)] ? 2'h2 : 2'h1);
    end
    results();
  end
endmodule : tlvic_ctrl_tb
